// File: hdl/mcw_comm_watchdog.sv
`timescale 1ns/100ps
// Functional notes
// - Watchdog arms on first write to the output data; no timeout before that.
// - Type one: any received read or write restarts the elapsed count.
// - Type zero: only writes restart the count; reads do not.
// - Fault when elapsed count reaches or exceeds the limit.
// - Fault forces terminal outputs off until unlock or restart.
// - Limit in milliseconds, resets to 1000; zero disables the watchdog.
// - Limit writes refused with code 02 when armed or faulted; reads always work.
// - Status bit 15 shows the fault; cleared by a correct unlock sequence.
// - During fault, writes to I/O data get exception code 4.
// - Read-only register gives milliseconds since last restarting message.
// - Serial variant refuses I/O reads in fault; network variant serves input reads.
// - Coupler registers stay readable in any fault state; type and unlock stay writable, limit writes are refused.
// - Watchdog disabled and link quiet: outputs hold their last values.
// - Without output terminals the watchdog never arms.
// - Watchdog indicator lit while healthy; receive and transmit indicators follow activity.
// - Link-error indicator lit on data error or lost communication.
module mcw_comm_watchdog #(
  parameter int unsigned TICK_CYCLES = mcw_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire mcw_pkg::mcw_req_type req,
  input wire logic outputsPresent,
  input wire logic serialVariant,
  input wire logic [15:0] inputWord,
  input wire logic rxActive,
  input wire logic txActive,
  input wire logic dataError,
  output mcw_pkg::mcw_resp_type resp,
  output logic [15:0] terminalOut,
  output mcw_pkg::mcw_led_type leds
);

  mcw_pkg::mcw_state_type st_r;
  mcw_pkg::mcw_state_type st_nxt;
  logic msTick;

  mcw_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) mcw_tick_div_inst (
    .clk(clk),
    .reset_n(reset_n),
    .tick(msTick)
  );

  // Whether a received message restarts the elapsed count
  function automatic logic restarts(input mcw_pkg::mcw_req_type r, input logic [15:0] wdType);
    restarts = r.valid && (r.write || (wdType == mcw_pkg::TYPE_READ_WRITE));
  endfunction

  // Whether the watchdog has run out
  function automatic logic expired(input mcw_pkg::mcw_state_type s);
    expired = s.armed && !s.fault && (s.limit != mcw_pkg::LIMIT_DISABLED) && (s.elapsed >= s.limit);
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.resp = '0;
    st_nxt.resp.valid = req.valid;
    // Counting stops during fault; the count is meaningless until unlock
    if (st_r.armed && !st_r.fault)
    begin
      if (restarts(req, st_r.wdType))
      begin
        st_nxt.elapsed = 16'h0000;
      end
      else if (msTick && (st_r.elapsed != mcw_pkg::ELAPSED_MAX))
      begin
        st_nxt.elapsed = st_r.elapsed + 16'h0001;
      end
    end
    if (expired(st_r))
    begin
      st_nxt.fault = 1'b1;
    end
    if (req.valid)
    begin
      case (req.addr)
        mcw_pkg::ADDR_STATUS:
        begin
          if (req.write)
          begin
            st_nxt.resp.exc = mcw_pkg::EXC_ILLEGAL_ADDR;
          end
          else
          begin
            st_nxt.resp.data[mcw_pkg::STATUS_FAULT_BIT] = st_r.fault;
          end
        end
        mcw_pkg::ADDR_ELAPSED:
        begin
          if (req.write)
          begin
            st_nxt.resp.exc = mcw_pkg::EXC_ILLEGAL_ADDR;
          end
          else
          begin
            st_nxt.resp.data = st_r.elapsed;
          end
        end
        mcw_pkg::ADDR_LIMIT:
        begin
          if (!req.write)
          begin
            st_nxt.resp.data = st_r.limit;
          end
          else if (st_r.armed || st_r.fault)
          begin
            st_nxt.resp.exc = mcw_pkg::EXC_ILLEGAL_ADDR;
          end
          else
          begin
            st_nxt.limit = req.data;
          end
        end
        mcw_pkg::ADDR_UNLOCK:
        begin
          if (!req.write)
          begin
            st_nxt.resp.data = st_r.unlockVal;
          end
          else
          begin
            st_nxt.unlockVal = req.data;
            st_nxt.unlockHalf = 1'b0;
            if (req.data == mcw_pkg::UNLOCK_KEY_FIRST)
            begin
              st_nxt.unlockHalf = 1'b1;
            end
            else if ((req.data == mcw_pkg::UNLOCK_KEY_SECOND) && st_r.unlockHalf && st_r.fault)
            begin
              // Disarm too, so the next output write starts a fresh watchdog
              st_nxt.fault = 1'b0;
              st_nxt.armed = 1'b0;
              st_nxt.elapsed = 16'h0000;
            end
          end
        end
        mcw_pkg::ADDR_TYPE:
        begin
          if (req.write)
          begin
            st_nxt.wdType = req.data;
          end
          else
          begin
            st_nxt.resp.data = st_r.wdType;
          end
        end
        mcw_pkg::ADDR_IN_DATA:
        begin
          if (req.write)
          begin
            st_nxt.resp.exc = st_r.fault ? mcw_pkg::EXC_DEVICE_FAIL : mcw_pkg::EXC_ILLEGAL_ADDR;
          end
          else if (st_r.fault && serialVariant)
          begin
            st_nxt.resp.exc = mcw_pkg::EXC_DEVICE_FAIL;
          end
          else
          begin
            st_nxt.resp.data = inputWord;
          end
        end
        mcw_pkg::ADDR_OUT_DATA:
        begin
          if (!outputsPresent)
          begin
            st_nxt.resp.exc = mcw_pkg::EXC_ILLEGAL_ADDR;
          end
          else if (st_r.fault)
          begin
            st_nxt.resp.exc = mcw_pkg::EXC_DEVICE_FAIL;
          end
          else if (req.write)
          begin
            st_nxt.outImage = req.data;
            st_nxt.armed = 1'b1;
            st_nxt.elapsed = 16'h0000;
          end
          else
          begin
            st_nxt.resp.data = st_r.outImage;
          end
        end
        default:
        begin
          st_nxt.resp.exc = mcw_pkg::EXC_ILLEGAL_ADDR;
        end
      endcase
    end
    // Outputs change only on an accepted write, a fault or an unlock; a quiet link without fault holds them
    st_nxt.termOut = st_nxt.fault ? 16'h0000 : st_nxt.outImage;
    st_nxt.led.watchdogOk = !st_nxt.fault;
    st_nxt.led.rx = rxActive;
    st_nxt.led.tx = txActive;
    st_nxt.led.linkErr = dataError || st_nxt.fault;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= mcw_pkg::STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign resp = st_r.resp;
  assign terminalOut = st_r.termOut;
  assign leds = st_r.led;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_NO_FAULT_UNARMED: assert property (!st_r.armed && !st_r.fault |=> !st_r.fault)
    else $error("Fault raised while watchdog unarmed");

  AST_RESTART_ANY: assert property (st_r.armed && !st_r.fault && req.valid
      && st_r.wdType == mcw_pkg::TYPE_READ_WRITE |=> st_r.elapsed == 16'h0000)
    else $error("Message did not restart elapsed count");

  AST_READ_NO_RESTART: assert property (st_r.armed && !st_r.fault && req.valid && !req.write
      && st_r.wdType == 16'h0000 && !msTick |=> st_r.elapsed == $past(st_r.elapsed))
    else $error("Read restarted count in write-only mode");

  AST_FAULT_AT_LIMIT: assert property (st_r.armed && !st_r.fault && st_r.limit != 16'h0000
      && st_r.elapsed >= st_r.limit |=> st_r.fault ##1 st_r.led.linkErr)
    else $error("No fault at limit");

  AST_OUTPUTS_OFF: assert property (st_r.fault |-> terminalOut == 16'h0000 && !leds.watchdogOk)
    else $error("Outputs live during fault");

  AST_LIMIT_ZERO: assert property (st_r.limit == 16'h0000 && !st_r.fault |=> !st_r.fault)
    else $error("Fault with watchdog disabled");

  AST_LIMIT_REFUSED: assert property (req.valid && req.write && req.addr == mcw_pkg::ADDR_LIMIT
      && (st_r.armed || st_r.fault) |=> resp.exc == 8'h02 && st_r.limit == $past(st_r.limit))
    else $error("Limit write not refused");

  AST_STATUS_BIT: assert property (req.valid && !req.write && req.addr == mcw_pkg::ADDR_STATUS
      |=> resp.valid && resp.data[mcw_pkg::STATUS_FAULT_BIT] == $past(st_r.fault))
    else $error("Status bit does not show fault");

  AST_UNLOCK: assert property (st_r.fault && st_r.unlockHalf && req.valid && req.write
      && req.addr == mcw_pkg::ADDR_UNLOCK && req.data == 16'hAFFE |=> !st_r.fault && !st_r.armed)
    else $error("Unlock did not clear fault");

  AST_IO_WRITE_EXC: assert property (st_r.fault && req.valid && req.write
      && req.addr == mcw_pkg::ADDR_OUT_DATA && outputsPresent |=> resp.exc == 8'h04)
    else $error("Output write in fault not answered with code 4");

  AST_NO_ARM: assert property (!outputsPresent && !st_r.armed |=> !st_r.armed)
    else $error("Armed without output terminals");

  AST_UNLOCK_ABANDON: assert property (req.valid && req.write && req.addr == mcw_pkg::ADDR_UNLOCK
      && req.data != 16'hBECF |=> !st_r.unlockHalf)
    else $error("Partial unlock sequence survived other value");

endmodule

// File: common/mcw_pkg.sv
package mcw_pkg;

  // Register map, word addresses as the master sends them
  localparam logic [15:0] ADDR_STATUS = 16'h100C;
  localparam logic [15:0] ADDR_ELAPSED = 16'h1020;
  localparam logic [15:0] ADDR_LIMIT = 16'h1120;
  localparam logic [15:0] ADDR_UNLOCK = 16'h1121;
  localparam logic [15:0] ADDR_TYPE = 16'h1122;
  // I/O data image
  localparam logic [15:0] ADDR_IN_DATA = 16'h0000;
  localparam logic [15:0] ADDR_OUT_DATA = 16'h0800;

  // Field positions
  localparam int STATUS_FAULT_BIT = 15;

  // Reset values
  localparam logic [15:0] LIMIT_RST = 16'h03E8;
  localparam logic [15:0] TYPE_RST = 16'h0001;

  // Field values
  localparam logic [15:0] TYPE_READ_WRITE = 16'h0001;
  localparam logic [15:0] LIMIT_DISABLED = 16'h0000;
  localparam logic [15:0] UNLOCK_KEY_FIRST = 16'hBECF;
  localparam logic [15:0] UNLOCK_KEY_SECOND = 16'hAFFE;
  localparam logic [15:0] ELAPSED_MAX = 16'hFFFF;

  // Exception codes, zero means accepted
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;

  // Time base
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_PERIOD_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
  } mcw_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] exc;
    logic [15:0] data;
  } mcw_resp_type;

  typedef struct packed {
    logic watchdogOk;
    logic rx;
    logic tx;
    logic linkErr;
  } mcw_led_type;

  typedef struct packed {
    logic armed;
    logic fault;
    logic unlockHalf;
    logic [15:0] elapsed;
    logic [15:0] limit;
    logic [15:0] unlockVal;
    logic [15:0] wdType;
    logic [15:0] outImage;
    logic [15:0] termOut;
    mcw_resp_type resp;
    mcw_led_type led;
  } mcw_state_type;

  localparam mcw_state_type STATE_RST = '{
    armed: 1'b0, fault: 1'b0, unlockHalf: 1'b0, elapsed: 16'h0000,
    limit: LIMIT_RST, unlockVal: 16'h0000, wdType: TYPE_RST,
    outImage: 16'h0000, termOut: 16'h0000,
    resp: '{valid: 1'b0, exc: EXC_NONE, data: 16'h0000},
    led: '{watchdogOk: 1'b1, rx: 1'b0, tx: 1'b0, linkErr: 1'b0}
  };

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } mcw_div_state_type;

endpackage

// File: hdl/mcw_tick_div.sv
`timescale 1ns/100ps
module mcw_tick_div #(
  parameter int unsigned CYCLES = mcw_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);

  mcw_pkg::mcw_div_state_type st_r;
  mcw_pkg::mcw_div_state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.count >= 32'(CYCLES - 1))
    begin
      st_nxt.count = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.count = st_r.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

// File: sim/mcw_master_model.sv
`timescale 1ns/100ps
module mcw_master_model (
  input wire logic clk,
  input wire mcw_pkg::mcw_resp_type resp,
  output mcw_pkg::mcw_req_type req
);
  initial req = '0;

  // Unsigned single-register accesses only
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
    output logic [7:0] exc, output logic [15:0] rd);
    // Called just after an edge; answer read at the following edge while it stands
    req <= '{valid: 1'b1, write: w, addr: a, data: d};
    @(posedge clk);
    // Released fields flip so stale values never look valid
    req <= '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
    @(posedge clk);
    exc = resp.valid ? resp.exc : 8'hFF;
    rd = resp.data;
  endtask

  task automatic unlock(output logic [7:0] exc);
    logic [15:0] rd;
    xfer(1'b1, mcw_pkg::ADDR_UNLOCK, mcw_pkg::UNLOCK_KEY_FIRST, exc, rd);
    xfer(1'b1, mcw_pkg::ADDR_UNLOCK, mcw_pkg::UNLOCK_KEY_SECOND, exc, rd);
  endtask
endmodule

// File: sim/modbus_comm_loss_watchdog_tb.sv
`timescale 1ns/100ps
module modbus_comm_loss_watchdog_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic outputsPresent = 1'b1;
  logic serialVariant = 1'b0;
  logic [15:0] inputWord = 16'h5A3C;
  logic rxActive = 1'b0;
  logic txActive = 1'b0;
  logic dataError = 1'b0;
  mcw_pkg::mcw_req_type req;
  mcw_pkg::mcw_resp_type resp;
  mcw_pkg::mcw_led_type leds;
  logic [15:0] terminalOut;
  logic [7:0] exc;
  logic [15:0] rdata;
  int errTotal = 0;
  int checkCount = 0;
  int cycles = 0;

  // Short tick keeps millisecond limits within a few dozen cycles
  mcw_comm_watchdog #(.TICK_CYCLES(10)) mcw_comm_watchdog_inst (
    .clk(clk), .reset_n(reset_n), .req(req), .outputsPresent(outputsPresent),
    .serialVariant(serialVariant), .inputWord(inputWord), .rxActive(rxActive),
    .txActive(txActive), .dataError(dataError), .resp(resp),
    .terminalOut(terminalOut), .leds(leds));

  mcw_master_model mcw_master_model_inst (.clk(clk), .resp(resp), .req(req));

  initial forever #10 clk = ~clk;

  task automatic final_report;
    $display("checks %0d errors %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errTotal = errTotal + 1;
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checkCount++;
    if (seen !== want)
    begin
      errTotal++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    mcw_master_model_inst.xfer(w, a, d, exc, rdata);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reset_pulse;
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
  endtask

  task automatic t_reset;
    acc(1'b0, mcw_pkg::ADDR_LIMIT, 16'h0000);
    check(rdata, 16'h03E8);
    acc(1'b0, mcw_pkg::ADDR_TYPE, 16'h0000);
    check(rdata, 16'h0001);
    acc(1'b1, mcw_pkg::ADDR_STATUS, 16'h0000);
    check({8'h00, exc}, 16'h0002);
    acc(1'b0, 16'h0F00, 16'h0000);
    check({8'h00, exc}, 16'h0002);
    check({15'h0, leds.watchdogOk}, 16'h0001);
  endtask

  task automatic t_no_out;
    acc(1'b1, mcw_pkg::ADDR_LIMIT, 16'h0003);
    check({8'h00, exc}, 16'h0000);
    outputsPresent <= 1'b0;
    acc(1'b1, mcw_pkg::ADDR_OUT_DATA, 16'h00FF);
    check({8'h00, exc}, 16'h0002);
    idle(80);
    acc(1'b0, mcw_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0, rdata[15]}, 16'h0000);
    outputsPresent <= 1'b1;
  endtask

  task automatic t_fault;
    acc(1'b1, mcw_pkg::ADDR_OUT_DATA, 16'h1234);
    check(terminalOut, 16'h1234);
    acc(1'b1, mcw_pkg::ADDR_LIMIT, 16'h0005);
    check({8'h00, exc}, 16'h0002);
    acc(1'b0, mcw_pkg::ADDR_LIMIT, 16'h0000);
    check(rdata, 16'h0003);
    idle(60);
    check(terminalOut, 16'h0000);
    check({14'h0, leds.watchdogOk, leds.linkErr}, 16'h0001);
    acc(1'b0, mcw_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0, rdata[15]}, 16'h0001);
    acc(1'b1, mcw_pkg::ADDR_OUT_DATA, 16'h5555);
    check({8'h00, exc}, 16'h0004);
    acc(1'b1, mcw_pkg::ADDR_LIMIT, 16'h0005);
    check({8'h00, exc}, 16'h0002);
    acc(1'b1, mcw_pkg::ADDR_TYPE, 16'h0001);
    check({8'h00, exc}, 16'h0000);
    acc(1'b0, mcw_pkg::ADDR_IN_DATA, 16'h0000);
    check(rdata, 16'h5A3C);
    serialVariant <= 1'b1;
    acc(1'b0, mcw_pkg::ADDR_IN_DATA, 16'h0000);
    check({8'h00, exc}, 16'h0004);
    serialVariant <= 1'b0;
  endtask

  task automatic t_unlock;
    acc(1'b1, mcw_pkg::ADDR_UNLOCK, mcw_pkg::UNLOCK_KEY_FIRST);
    acc(1'b1, mcw_pkg::ADDR_UNLOCK, 16'h1111);
    acc(1'b1, mcw_pkg::ADDR_UNLOCK, mcw_pkg::UNLOCK_KEY_SECOND);
    acc(1'b0, mcw_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0, rdata[15]}, 16'h0001);
    mcw_master_model_inst.unlock(exc);
    acc(1'b0, mcw_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0, rdata[15]}, 16'h0000);
    check(terminalOut, 16'h1234);
  endtask

  task automatic t_retrig;
    acc(1'b1, mcw_pkg::ADDR_OUT_DATA, 16'h00C3);
    repeat (8)
    begin
      idle(12);
      acc(1'b0, mcw_pkg::ADDR_ELAPSED, 16'h0000);
      check({15'h0, rdata inside {16'h0001, 16'h0002}}, 16'h0001);
    end
    check(terminalOut, 16'h00C3);
    acc(1'b1, mcw_pkg::ADDR_TYPE, 16'h0000);
    repeat (8)
    begin
      idle(12);
      acc(1'b0, mcw_pkg::ADDR_IN_DATA, 16'h0000);
    end
    check(terminalOut, 16'h0000);
    mcw_master_model_inst.unlock(exc);
  endtask

  task automatic t_disabled;
    acc(1'b1, mcw_pkg::ADDR_LIMIT, 16'h0000);
    check({8'h00, exc}, 16'h0000);
    acc(1'b1, mcw_pkg::ADDR_OUT_DATA, 16'h00AA);
    idle(300);
    check(terminalOut, 16'h00AA);
    check({15'h0, leds.watchdogOk}, 16'h0001);
  endtask

  task automatic t_leds;
    rxActive <= 1'b1;
    dataError <= 1'b1;
    idle(3);
    check({13'h0, leds.rx, leds.tx, leds.linkErr}, 16'h0005);
    rxActive <= 1'b0;
    txActive <= 1'b1;
    dataError <= 1'b0;
    idle(3);
    check({13'h0, leds.rx, leds.tx, leds.linkErr}, 16'h0002);
  endtask

  // Restart in mid-run must clear a fault and restore defaults
  task automatic t_restart;
    reset_pulse();
    acc(1'b1, mcw_pkg::ADDR_LIMIT, 16'h0002);
    check({8'h00, exc}, 16'h0000);
    acc(1'b1, mcw_pkg::ADDR_OUT_DATA, 16'h0F0F);
    idle(40);
    check(terminalOut, 16'h0000);
    reset_pulse();
    acc(1'b0, mcw_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0, rdata[15]}, 16'h0000);
    acc(1'b0, mcw_pkg::ADDR_LIMIT, 16'h0000);
    check(rdata, 16'h03E8);
    check({15'h0, leds.watchdogOk}, 16'h0001);
  endtask

  initial
  begin
    idle(3);
    reset_n <= 1'b1;
    t_reset();
    t_no_out();
    t_fault();
    t_unlock();
    t_retrig();
    t_disabled();
    t_leds();
    t_restart();
    final_report();
  end
endmodule
